// File: src/swr_rom_id.sv
// Single-wire slave: reset and presence, bit slots, identity commands, CRC.
// Assumes the line input is synchronous to clk_i; the pin is open drain and
// is pulled low only while dq_oe_o is high.
//
// Notes on behaviour
// [R1] Fixed 64-bit code: family, serial, CRC.
// [R2] CRC polynomial x8 + x5 + x4 + 1.
// [R3] CRC cleared, fed LSB first from family.
// [R4] Receiver CRC over all 64 bits is zero.
// [R5] Memory functions locked until identity command done.
// [R6] One identity command per reset, six supported.
// [R7] Overdrive commands switch to overdrive speed.
// [R8] Regular 16.3k, overdrive up to 142k bit/s.
// [R9] Bytes travel least significant bit first.
// [R10] Flag raised while programming voltage present.
// [R11] Programming only clears bits, never sets.
// [R12] Presence pulse answers each bus reset.
// [R13] Match and search single out one device.
// [R14] CRC step: shift right, xor feedback taps.
`timescale 1ns/100ps
module swr_rom_id
  import swr_pkg::*;
#(
  parameter logic [7:0]       FAMILY_CODE = FAMILY_DEF,  // Arbitrary value
  parameter logic [47:0]      SERIAL_NUM  = SERIAL_DEF,  // Arbitrary value
  parameter logic [CNT_W-1:0] RST_STD_CYC = CNT_W'(C_RST_STD),
  parameter logic [CNT_W-1:0] RST_OD_CYC  = CNT_W'(C_RST_OD),
  parameter logic [CNT_W-1:0] SMP_STD_CYC = CNT_W'(C_SMP_STD),
  parameter logic [CNT_W-1:0] PW_STD_CYC  = CNT_W'(C_PW_STD),
  parameter logic [CNT_W-1:0] PL_STD_CYC  = CNT_W'(C_PL_STD)
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Data line, open drain
  input  wire logic       dq_i,
  output logic            dq_o,
  output logic            dq_oe_o,
  // Programming voltage detect and one-way programming
  input  wire logic       vpp_det_i,
  input  wire logic [7:0] pgm_cur_i,
  input  wire logic [7:0] pgm_dat_i,
  output logic            prog_det_o,
  output logic [7:0]      pgm_res_o,
  // Memory function layer
  output logic            mem_open_o,
  output logic            mem_stb_o,
  output logic [7:0]      mem_byte_o,
  output logic            od_o
);

  // ********************************************************************
  // Identity code
  // ********************************************************************
  localparam logic [55:0] ID_BODY  = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] ROM_CODE = {crc8_calc(ID_BODY), ID_BODY}; // [R1] [R3]

  localparam logic [CNT_W-1:0] SMP_OD_CYC = CNT_W'(C_SMP_OD);
  localparam logic [CNT_W-1:0] PW_OD_CYC  = CNT_W'(C_PW_OD);
  localparam logic [CNT_W-1:0] PL_OD_CYC  = CNT_W'(C_PL_OD);
  localparam logic [CNT_W-1:0] CNT_MAX    = '1;

  swr_st_t          s_r;
  swr_st_t          s_nxt;
  logic             evt;
  logic             rbit;
  logic             byte_done;
  logic [7:0]       rx_byte;
  logic             rst_seen;
  logic [CNT_W-1:0] smp_cyc;
  logic [CNT_W-1:0] pw_cyc;
  logic [CNT_W-1:0] pl_cyc;
  logic             txb;
  logic             is_tx;
  logic             slotting;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.mem_stb = 1'b0;
    s_nxt.prev    = dq_i;
    rbit      = dq_i;
    evt       = 1'b0;
    byte_done = 1'b0;
    rst_seen  = 1'b0;
    rx_byte   = {dq_i, s_r.shreg[7:1]};                   // [R9]
    // Slot timing follows the speed mode
    smp_cyc   = s_r.od ? SMP_OD_CYC : SMP_STD_CYC;       // [R8]
    pw_cyc    = s_r.od ? PW_OD_CYC  : PW_STD_CYC;
    pl_cyc    = s_r.od ? PL_OD_CYC  : PL_STD_CYC;
    slotting  = (s_r.state == ST_CMD) || (s_r.state == ST_READ) ||
                (s_r.state == ST_MATCH) || (s_r.state == ST_SEARCH) ||
                (s_r.state == ST_MEM);

    // Programming voltage flag and one-way bit merge
    s_nxt.prog_det = vpp_det_i;                            // [R10]
    s_nxt.pgm_res  = pgm_cur_i & pgm_dat_i;                // [R11]

    // Slot window: starts on a master falling edge, ends at sample point
    if (s_r.slot_act)
    begin
      if (s_r.cnt >= smp_cyc)
      begin
        evt            = 1'b1;
        s_nxt.slot_act = 1'b0;
      end
      else
        s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (slotting && s_r.prev && !dq_i)
    begin
      s_nxt.slot_act = 1'b1;
      s_nxt.cnt      = '0;
    end

    unique case (s_r.state)
      ST_IDLE: ;
      // Presence pulse after a reset
      ST_PRES_WAIT:
      begin
        if (s_r.cnt >= pw_cyc)                             // [R12]
        begin
          s_nxt.state = ST_PRES_LOW;
          s_nxt.cnt   = '0;
        end
        else
          s_nxt.cnt = s_r.cnt + 1'b1;
      end
      ST_PRES_LOW:
      begin
        if (s_r.cnt >= pl_cyc)
        begin
          s_nxt.state = ST_CMD;
          s_nxt.bcnt  = 3'h0;
        end
        else
          s_nxt.cnt = s_r.cnt + 1'b1;
      end
      // Receive bytes LSB first: identity command or memory traffic
      ST_CMD, ST_MEM:
      begin
        if (evt)
        begin
          s_nxt.shreg = rx_byte;                           // [R9]
          s_nxt.bcnt  = s_r.bcnt + 1'b1;
          byte_done   = (s_r.bcnt == 3'h7);
        end
        if (byte_done && s_r.state == ST_MEM)
        begin
          s_nxt.mem_byte = rx_byte;                        // [R5]
          s_nxt.mem_stb  = 1'b1;
        end
        if (byte_done && s_r.state == ST_CMD)
        begin
          s_nxt.idx = 6'h00;
          s_nxt.sub = 2'h0;
          s_nxt.crc = 8'h00;                               // [R3]
          unique case (rx_byte)                            // [R6]
            CMD_READ:     s_nxt.state = ST_READ;
            CMD_MATCH:    s_nxt.state = ST_MATCH;
            CMD_SEARCH:   s_nxt.state = ST_SEARCH;
            CMD_SKIP:     s_nxt.state = ST_MEM;
            CMD_OD_SKIP:
            begin
              s_nxt.state = ST_MEM;
              s_nxt.od    = 1'b1;                          // [R7]
            end
            CMD_OD_MATCH:
            begin
              s_nxt.state = ST_MATCH;
              s_nxt.od    = 1'b1;                          // [R7]
            end
            default:      s_nxt.state = ST_IDLE;
          endcase
        end
      end
      // Send the 64-bit code, running the CRC alongside
      ST_READ:
      begin
        if (evt)
        begin
          s_nxt.crc = crc8_step(s_r.crc, ROM_CODE[s_r.idx]); // [R14] [R2]
          s_nxt.idx = s_r.idx + 1'b1;
          if (s_r.idx == LAST_BIT)
            s_nxt.state = ST_MEM;                          // [R5]
        end
      end
      // Compare master bits against the code; drop out on mismatch
      ST_MATCH:
      begin
        if (evt)
        begin
          if (rbit != ROM_CODE[s_r.idx])
            s_nxt.state = ST_IDLE;                         // [R13]
          else if (s_r.idx == LAST_BIT)
            s_nxt.state = ST_MEM;
          else
            s_nxt.idx = s_r.idx + 1'b1;
        end
      end
      // Bit, complement, then master's choice
      ST_SEARCH:
      begin
        if (evt)
        begin
          if (s_r.sub != 2'h2)
            s_nxt.sub = s_r.sub + 1'b1;
          else
          begin
            s_nxt.sub = 2'h0;
            if (rbit != ROM_CODE[s_r.idx])
              s_nxt.state = ST_IDLE;                       // [R13]
            else if (s_r.idx == LAST_BIT)
              s_nxt.state = ST_MEM;
            else
              s_nxt.idx = s_r.idx + 1'b1;
          end
        end
      end
    endcase

    // Reset detection: a long low pulse restarts the protocol
    if (!dq_i)
      s_nxt.low_cnt = (s_r.low_cnt == CNT_MAX) ? s_r.low_cnt : s_r.low_cnt + 1'b1;
    else
      s_nxt.low_cnt = '0;
    if (dq_i && !s_r.prev &&
        (s_r.low_cnt >= RST_STD_CYC || (s_r.od && s_r.low_cnt >= RST_OD_CYC)))
    begin
      rst_seen       = 1'b1;
      s_nxt.state    = ST_PRES_WAIT;                       // [R12] [R6]
      s_nxt.cnt      = '0;
      s_nxt.slot_act = 1'b0;
      s_nxt.mem_stb  = 1'b0;
      if (s_r.low_cnt >= RST_STD_CYC)
        s_nxt.od = 1'b0;                                   // [R8]
    end

    // Line drive: presence, or a zero bit in a read slot
    is_tx = (s_nxt.state == ST_READ) ||
            (s_nxt.state == ST_SEARCH && s_nxt.sub != 2'h2);
    txb   = ROM_CODE[s_nxt.idx] ^ (s_nxt.state == ST_SEARCH && s_nxt.sub == 2'h1);
    s_nxt.drv = (s_nxt.state == ST_PRES_LOW) || (s_nxt.slot_act && is_tx && !txb);
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      s_r          <= '0;
      s_r.state    <= ST_IDLE;
      s_r.prev     <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs
  assign dq_o       = 1'b0;
  assign dq_oe_o    = s_r.drv;
  assign prog_det_o = s_r.prog_det;
  assign pgm_res_o  = s_r.pgm_res;
  assign mem_open_o = (s_r.state == ST_MEM);
  assign mem_stb_o  = s_r.mem_stb;
  assign mem_byte_o = s_r.mem_byte;
  assign od_o       = s_r.od;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_read_bit;
    (s_r.state == ST_READ && s_r.slot_act) |-> (dq_oe_o == !ROM_CODE[s_r.idx]);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read slot drive wrong"); // [R1]
  property p_crc_zero;
    (s_r.state == ST_READ && evt && s_r.idx == LAST_BIT && !rst_seen)
      |=> (s_r.crc == 8'h00 && s_r.state == ST_MEM);
  endproperty
  a_crc_zero: assert property (p_crc_zero) else $error("code CRC not zero"); // [R3] [R4]
  property p_crc_step;
    (s_r.state == ST_READ && evt && !rst_seen)
      |=> s_r.crc == crc8_step($past(s_r.crc), ROM_CODE[$past(s_r.idx)]);
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("CRC step wrong"); // [R2] [R14]
  property p_mem_gate;
    mem_stb_o |-> (mem_open_o && $past(mem_open_o));
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory byte while locked"); // [R5]
  property p_skip;
    (s_r.state == ST_CMD && byte_done && rx_byte == CMD_SKIP && !rst_seen) |=> mem_open_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not open memory"); // [R6]
  property p_od;
    (s_r.state == ST_CMD && byte_done && !rst_seen &&
     (rx_byte == CMD_OD_SKIP || rx_byte == CMD_OD_MATCH)) |=> od_o;
  endproperty
  a_od: assert property (p_od) else $error("overdrive not entered"); // [R7]
  property p_rate;
    (s_r.slot_act && s_r.od) |-> s_r.cnt <= SMP_OD_CYC;
  endproperty
  a_rate: assert property (p_rate) else $error("overdrive slot too long"); // [R8]
  property p_lsb;
    (s_r.state == ST_MEM && byte_done && !rst_seen) |=> mem_byte_o == $past(rx_byte);
  endproperty
  a_lsb: assert property (p_lsb) else $error("byte assembly wrong"); // [R9]
  property p_vpp;
    vpp_det_i |=> prog_det_o;
  endproperty
  a_vpp: assert property (p_vpp) else $error("voltage flag missing"); // [R10]
  property p_one_way;
    1'b1 |=> (pgm_res_o & ~$past(pgm_cur_i)) == 8'h00;
  endproperty
  a_one_way: assert property (p_one_way) else $error("bit set by programming"); // [R11]
  sequence s_pw_end;
    s_r.state == ST_PRES_WAIT && s_r.cnt >= pw_cyc && !rst_seen;
  endsequence
  sequence s_pl_on;
    dq_oe_o && s_r.state == ST_PRES_LOW;
  endsequence
  property p_pres;
    s_pw_end |=> s_pl_on;
  endproperty
  a_pres: assert property (p_pres) else $error("no presence pulse"); // [R12]
  property p_drop;
    (s_r.state == ST_SEARCH && evt && s_r.sub == 2'h2 && !rst_seen &&
     rbit != ROM_CODE[s_r.idx]) |=> s_r.state == ST_IDLE ##1 !dq_oe_o;
  endproperty
  a_drop: assert property (p_drop) else $error("search did not drop out"); // [R13]

endmodule : swr_rom_id

// File: shared/swr_pkg.sv
// Package for the single-wire identity layer: timing, commands, CRC helpers, state.
// Assumes a 250 MHz clock; all times are converted to clock cycles here.
package swr_pkg;

  // ********************************************************************
  // Clock and slot timing
  // ********************************************************************
  localparam int CLK_PERIOD_PS = 4000;    // 250 MHz
  localparam int CNT_W         = 18;      // Widest count is the regular reset
  localparam int T_RST_STD_NS  = 480000;  // Least reset low, regular speed
  localparam int T_RST_OD_NS   = 48000;   // Least reset low, overdrive
  localparam int T_SMP_STD_NS  = 30000;   // Sample and hold point, regular
  localparam int T_SMP_OD_NS   = 3000;    // Sample and hold point, overdrive
  localparam int T_PW_STD_NS   = 30000;   // Wait before presence, regular
  localparam int T_PW_OD_NS    = 3000;    // Wait before presence, overdrive
  localparam int T_PL_STD_NS   = 120000;  // Presence low time, regular
  localparam int T_PL_OD_NS    = 12000;   // Presence low time, overdrive

  // Nanoseconds to whole cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int C_RST_STD = cyc_up(T_RST_STD_NS);
  localparam int C_RST_OD  = cyc_up(T_RST_OD_NS);
  localparam int C_SMP_STD = cyc_up(T_SMP_STD_NS);
  localparam int C_SMP_OD  = cyc_up(T_SMP_OD_NS);
  localparam int C_PW_STD  = cyc_up(T_PW_STD_NS);
  localparam int C_PW_OD   = cyc_up(T_PW_OD_NS);
  localparam int C_PL_STD  = cyc_up(T_PL_STD_NS);
  localparam int C_PL_OD   = cyc_up(T_PL_OD_NS);

  // ********************************************************************
  // Identity commands and code
  // ********************************************************************
  localparam logic [7:0]  CMD_READ     = 8'h33;
  localparam logic [7:0]  CMD_MATCH    = 8'h55;
  localparam logic [7:0]  CMD_SEARCH   = 8'hF0;
  localparam logic [7:0]  CMD_SKIP     = 8'hCC;
  localparam logic [7:0]  CMD_OD_SKIP  = 8'h3C;
  localparam logic [7:0]  CMD_OD_MATCH = 8'h69;
  localparam logic [7:0]  CRC_TAPS     = 8'h8C;           // x8+x5+x4+1, reflected
  localparam logic [7:0]  FAMILY_DEF   = 8'h5A;           // Arbitrary value
  localparam logic [47:0] SERIAL_DEF   = 48'h0123456789AB; // Arbitrary value
  localparam logic [5:0]  LAST_BIT     = 6'h3F;

  // One CRC step: feedback is input bit xor low bit, shift right
  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = b ^ c[0];
    return (c >> 1) ^ (fb ? CRC_TAPS : 8'h00);
  endfunction : crc8_step

  // CRC over the first 56 code bits, LSB first, from a cleared accumulator
  function automatic logic [7:0] crc8_calc(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = crc8_step(c, d[i]);
    return c;
  endfunction : crc8_calc

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRES_WAIT, ST_PRES_LOW, ST_CMD, ST_READ, ST_MATCH, ST_SEARCH, ST_MEM
  } swr_state_t;

  typedef struct packed {
    swr_state_t       state;
    logic             od;
    logic             prev;
    logic             drv;
    logic             slot_act;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] cnt;
    logic [5:0]       idx;
    logic [1:0]       sub;
    logic [7:0]       shreg;
    logic [2:0]       bcnt;
    logic [7:0]       crc;
    logic             prog_det;
    logic [7:0]       pgm_res;
    logic [7:0]       mem_byte;
    logic             mem_stb;
  } swr_st_t;

endpackage : swr_pkg

// File: test/swr_master_model.sv
// Bus master model for the single-wire identity layer: reset pulse, slots, bytes.
// Assumes its tasks are entered just after a rising edge; the line has a pull-up.
`timescale 1ns/100ps
module swr_master_model
  import swr_pkg::*;
(
  // Clock and line
  input  wire logic clk_i,
  input  wire logic dq_i,
  output logic      pull_o
);
  // ********************************************************************
  // Slot engine
  // ********************************************************************
  int smp = 20;  // Device sample point in cycles, raised for overdrive

  initial pull_o = 1'b0;

  // Pull low for n cycles, then release to the pull-up level
  task automatic low_for(input int n);
    pull_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_o <= 1'b0;
  endtask : low_for

  // Write slot: zero held past the sample point, one released early
  task automatic write_bit(input logic b);
    low_for(b ? 2 : smp + 10);
    repeat (b ? smp + 13 : 5) @(posedge clk_i);
  endtask : write_bit

  // Read slot: short low, sample the line well before the sample point
  task automatic read_bit(output logic b);
    low_for(2);
    repeat (smp / 2) @(posedge clk_i);
    b = dq_i;
    repeat (smp / 2 + 13) @(posedge clk_i);
  endtask : read_bit

  // Whole byte, least significant bit first
  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      write_bit(v[i]);
  endtask : write_byte

  // Reset pulse, then count low cycles of the answer within a window
  task automatic reset_bus(input int len, input int win, output int pres);
    low_for(len);
    pres = 0;
    repeat (win)
    begin
      @(posedge clk_i);
      if (dq_i === 1'b0)
        pres++;
    end
  endtask : reset_bus
endmodule : swr_master_model

// File: test/single_wire_rom_id_crc8_tb_top.sv
// Testbench for the single-wire identity layer, driven through a master model.
// Assumes shortened reset, sample and presence counts given at the instance.
`timescale 1ns/100ps
module single_wire_rom_id_crc8_tb_top
  import swr_pkg::*;
;
  // ********************************************************************
  // Signals, instances, clock
  // ********************************************************************
  localparam int PL      = 40;
  localparam int RST_LEN = 1024; // Reset pulse, equal to the regular reset count and above the overdrive one
  logic        clk_i = 1'b0;
  logic        nrst_i, vpp_det_i, dq_i, pull;
  logic        dq_o, dq_oe_o, prog_det_o, mem_open_o, mem_stb_o, od_o;
  logic [7:0]  pgm_cur_i, pgm_dat_i, pgm_res_o, mem_byte_o;
  logic [63:0] code_x;
  int          failures = 0, total_checks = 0, stb_cnt = 0, cyc = 0;
  integer      seed = 32'hE8EC;

  // Open-drain line: low when either side pulls
  assign dq_i = ~(pull | dq_oe_o);

  // Both reset counts stay above the 760-cycle overdrive zero slot
  swr_rom_id #(
    .RST_STD_CYC (18'h00400),
    .RST_OD_CYC  (18'h00320),
    .SMP_STD_CYC (18'h00014),
    .PW_STD_CYC  (18'h0000A),
    .PL_STD_CYC  (18'h00028)
  ) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .vpp_det_i(vpp_det_i), .pgm_cur_i(pgm_cur_i), .pgm_dat_i(pgm_dat_i),
    .prog_det_o(prog_det_o), .pgm_res_o(pgm_res_o), .mem_open_o(mem_open_o),
    .mem_stb_o(mem_stb_o), .mem_byte_o(mem_byte_o), .od_o(od_o)
  );

  swr_master_model MST (.clk_i(clk_i), .dq_i(dq_i), .pull_o(pull));

  // Clock
  always #2 clk_i = ~clk_i;

  // Strobe counter and hang limit
  always @(posedge clk_i)
  begin
    if (mem_stb_o === 1'b1)
      stb_cnt <= stb_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      end_of_test();
    end
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Reference check byte over the first n bits, shift right with reflected taps
  function automatic logic [7:0] crc_ref(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++)
      c = (c >> 1) ^ ((d[i] ^ c[0]) ? 8'h8C : 8'h00);
    return c;
  endfunction : crc_ref

  // Regular-speed reset, presence, then one command byte
  task automatic open_cmd(input logic [7:0] cmd, output int pres);
    MST.smp = 20;
    MST.reset_bus(RST_LEN, 100, pres);
    MST.write_byte(cmd);
  endtask : open_cmd

  // Random memory-layer byte; strobed only when unlocked
  task automatic mem_byte(input logic ok);
    logic [7:0] v;
    int         n0;
    v = 8'($random(seed));
    n0 = stb_cnt;
    MST.write_byte(v);
    check("mem_stb", 64'(stb_cnt), 64'(n0 + (ok ? 1 : 0)));
    if (ok)
      check("mem_byte", mem_byte_o, v);
  endtask : mem_byte

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    logic [63:0] got, gotn, bad;
    logic [7:0]  c, d;
    logic        vb;
    logic [7:0]  cmds [4];
    int          p, k;
    cmds = '{CMD_SKIP, CMD_OD_SKIP, CMD_MATCH, CMD_SEARCH};
    code_x = {8'h00, SERIAL_DEF, FAMILY_DEF};
    code_x[63:56] = crc_ref(code_x, 56);
    nrst_i <= 1'b0;
    vpp_det_i <= 1'b0;
    pgm_cur_i <= 8'h00;
    pgm_dat_i <= 8'h00;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    check("reset_out", {dq_o, od_o, mem_open_o, dq_oe_o, mem_stb_o, prog_det_o}, 0);
    // Read identity: presence length, code order and check byte
    open_cmd(CMD_READ, p);
    check("presence", 64'(p), 64'(PL + 1));
    check("mem_open", mem_open_o, 0);
    for (int i = 0; i < 64; i++)
      MST.read_bit(got[i]);
    check("code", got, code_x);
    check("crc", got[63:56], crc_ref(got, 56));
    check("crc_rx", crc_ref(got, 64), 0);
    check("mem_open", mem_open_o, 1);
    // Unknown command keeps memory functions locked
    do
      c = 8'($random(seed));
    while (c inside {CMD_READ, CMD_MATCH, CMD_SEARCH, CMD_SKIP, CMD_OD_SKIP, CMD_OD_MATCH});
    open_cmd(c, p);
    mem_byte(1'b0);
    check("mem_lock", mem_open_o, 0);
    // Skip, overdrive skip, match and search, then one memory byte at the resulting speed
    foreach (cmds[j])
    begin
      open_cmd(cmds[j], p);
      if (cmds[j] == CMD_MATCH)
        for (int i = 0; i < 64; i++)
          MST.write_bit(code_x[i]);
      if (cmds[j] == CMD_SEARCH)
      begin
        for (int i = 0; i < 64; i++)
        begin
          MST.read_bit(got[i]);
          MST.read_bit(gotn[i]);
          MST.write_bit(code_x[i]);
        end
        check("search_bit", got, code_x);
        check("search_cmp", gotn, ~code_x);
      end
      check("od", od_o, 64'(cmds[j] == CMD_OD_SKIP));
      check("mem_unlock", mem_open_o, 1);
      if (cmds[j] == CMD_OD_SKIP)
        MST.smp = 750;
      mem_byte(1'b1);
    end
    // Match with one wrong code bit deselects
    k = int'($unsigned($random(seed)) % 64);
    bad = code_x ^ (64'h1 << k);
    open_cmd(CMD_MATCH, p);
    for (int i = 0; i < 64; i++)
      MST.write_bit(bad[i]);
    check("match_drop", mem_open_o, 0);
    mem_byte(1'b0);
    // Search with a wrong first choice: later slots see no drive
    open_cmd(CMD_SEARCH, p);
    MST.read_bit(vb);
    MST.read_bit(vb);
    MST.write_bit(~code_x[0]);
    MST.read_bit(got[0]);
    MST.read_bit(gotn[0]);
    check("search_drop", {got[0], gotn[0]}, 2'h3);
    // Overdrive match switches speed after its command byte
    open_cmd(CMD_OD_MATCH, p);
    check("od_match", od_o, 1);
    // One-way programming merge and voltage detect
    repeat (20)
    begin
      c = 8'($random(seed));
      d = 8'($random(seed));
      vb = 1'($random(seed));
      pgm_cur_i <= c;
      pgm_dat_i <= d;
      vpp_det_i <= vb;
      repeat (2) @(posedge clk_i);
      check("pgm_res", pgm_res_o, c & d);
      check("prog_det", prog_det_o, vb);
    end
    end_of_test();
  end
endmodule : single_wire_rom_id_crc8_tb_top
